// [hw/fbsl_consts.vh]
// constants for the fieldbus slave command map
// Overview of operation
// - command 0000 executes action chosen by data: 10,11,12,13,14,15,17,20
// - setting 5710 picks zero/hold/clear source: 0 terminal, 1 network bits
// - setting 5711 picks store trigger: 0 manual command, 1 network bits
// - setting 5101 sets stations occupied: 0 four, 1 two, 2 one
// - setting 5102 holds station number 1..64, upper bound shrinks with stations
// - setting 5103 picks bit rate: 10M, 5M, 2.5M, 625k, 156k
// - station count, number and rate apply only after next power-up
// - run lamp off when not joined or on carrier fault or timeout
// - run lamp lit when joined and refresh and polling arrive normally
// - error lamp off when normal, lit on frame check or setting error
// - error lamp blinks when network settings changed while linked
// - transmit lamp lit while the device transmits, three clocks behind
// - receive lamp lit while carrier detected, off otherwise
// - status word: 15 over, 14 full, 13 stable, 10..8 point, 3..1 limits
// - fault code 0 none, 1 system, 2 calibration, 3 range, 4 command
`ifndef FBSL_CONSTS_VH
`define FBSL_CONSTS_VH

// --------------------
// word addresses
// --------------------
`define FBSL_ADR_UPPER_LO   10'h1E2
`define FBSL_ADR_UPPER_HI   10'h1E3
`define FBSL_ADR_LOWER_LO   10'h1E4
`define FBSL_ADR_LOWER_HI   10'h1E5
`define FBSL_ADR_NEAR_LO    10'h1E8
`define FBSL_ADR_NEAR_HI    10'h1E9
`define FBSL_ADR_HYST_LO    10'h1EA
`define FBSL_ADR_HYST_HI    10'h1EB
`define FBSL_ADR_ARG_LO     10'h1EC
`define FBSL_ADR_ARG_HI     10'h1ED
`define FBSL_ADR_CODE       10'h1EE
`define FBSL_ADR_DISP_LO    10'h2E0
`define FBSL_ADR_DISP_HI    10'h2E1
`define FBSL_ADR_LIVE_LO    10'h2E2
`define FBSL_ADR_LIVE_HI    10'h2E3
`define FBSL_ADR_STATUS     10'h2E4
`define FBSL_ADR_RES_LO     10'h2EC
`define FBSL_ADR_RES_HI     10'h2ED
`define FBSL_ADR_ECHO       10'h2EE
`define FBSL_ADR_FAULT      10'h2EF

// --------------------
// command numbers and execution codes
// --------------------
`define FBSL_CMD_EXEC       16'h0000
`define FBSL_CMD_POLL       16'h0001
`define FBSL_CMD_POLL_ST    16'h0002
`define FBSL_CMD_POLL_VAL   16'h0003
`define FBSL_SET_CTRL_SRC   16'h5710
`define FBSL_SET_MEM_SRC    16'h5711
`define FBSL_SET_STATIONS   16'h5101
`define FBSL_SET_STN_NO     16'h5102
`define FBSL_SET_SPEED      16'h5103
`define FBSL_EX_ZERO        32'h00000010
`define FBSL_EX_ZERO_CLR    32'h00000011
`define FBSL_EX_HOLD_ON     32'h00000012
`define FBSL_EX_HOLD_OFF    32'h00000013
`define FBSL_EX_HOLD_LOCK   32'h00000014
`define FBSL_EX_HOLD_CLR    32'h00000015
`define FBSL_EX_HOME        32'h00000017
`define FBSL_EX_STRAIN      32'h00000020

// --------------------
// setting ranges and defaults
// --------------------
`define FBSL_STATIONS_MAX   2'h2
`define FBSL_SPEED_MAX      3'h4
`define FBSL_STN_MIN        7'h01
`define FBSL_STN_MAX_4      7'h3D
`define FBSL_STN_MAX_2      7'h3F
`define FBSL_STN_MAX_1      7'h40

// --------------------
// command state and fault codes
// --------------------
`define FBSL_CST_STANDBY    2'h0
`define FBSL_CST_EXEC       2'h1
`define FBSL_CST_ERROR      2'h2
`define FBSL_FLT_NONE       16'h0000
`define FBSL_FLT_SYSTEM     16'h0001
`define FBSL_FLT_CAL        16'h0002
`define FBSL_FLT_RANGE      16'h0003
`define FBSL_FLT_CMD        16'h0004

// --------------------
// timing
// --------------------
`define FBSL_CLK_HZ         20000000
`define FBSL_BLINK_MS       250
`define FBSL_BLINK_CYC      ((`FBSL_CLK_HZ / 1000) * `FBSL_BLINK_MS)

`endif

// [hw/fbsl_sync.v]
// two-stage synchroniser bank for asynchronous inputs
`timescale 1ns/100ps
module fbsl_sync #(
  parameter WIDTH = 1
) (
  input  wire             clk_i,
  input  wire             rst_n_i,
  input  wire [WIDTH-1:0] async_i,
  output wire [WIDTH-1:0] sync_o
);
  reg [WIDTH-1:0] stage1;
  reg [WIDTH-1:0] stage2;

  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : bit_sync
      always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          stage1[g] <= 1'b0;
          stage2[g] <= 1'b0;
        end else begin
          stage1[g] <= async_i[g];
          stage2[g] <= stage1[g];
        end
      end
    end
  endgenerate

  assign sync_o = stage2;
endmodule

// [hw/fbsl_top.v]
// fieldbus slave command map: link words, commands, settings and lamps
`timescale 1ns/100ps
`include "fbsl_consts.vh"
module fbsl_top #(
  parameter BLINK_CYC = `FBSL_BLINK_CYC
) (
  input  wire        clk_i,
  input  wire        nrst_i,
  // link word access
  input  wire [9:0]  link_addr_i,
  input  wire [15:0] link_wdata_i,
  input  wire        link_we_i,
  input  wire        link_re_i,
  output reg  [15:0] link_rdata_o,
  // link state
  input  wire        carrier_i,
  input  wire        transmitting_i,
  input  wire        joined_i,
  input  wire        refresh_ok_i,
  input  wire        timeout_i,
  input  wire        crc_err_i,
  // local setting port
  input  wire        set_we_i,
  input  wire [15:0] set_num_i,
  input  wire [15:0] set_val_i,
  output reg         set_err_o,
  // stored network settings, caught at power-up
  input  wire        nv_ctrl_src_i,
  input  wire        nv_mem_src_i,
  input  wire [1:0]  nv_stations_i,
  input  wire [6:0]  nv_station_no_i,
  input  wire [2:0]  nv_speed_i,
  output reg  [1:0]  pend_stations_o,
  output reg  [6:0]  pend_station_no_o,
  output reg  [2:0]  pend_speed_o,
  output reg  [1:0]  act_stations_o,
  output reg  [6:0]  act_station_no_o,
  output reg  [2:0]  act_speed_o,
  // measurement side
  input  wire [31:0] display_value_i,
  input  wire [31:0] live_input_value_i,
  input  wire        over_i,
  input  wire        full_i,
  input  wire        stable_i,
  input  wire        strain_i,
  input  wire [2:0]  point_pos_i,
  input  wire        hold_active_i,
  input  wire        zone_hold_i,
  input  wire        near_zero_i,
  input  wire        upper_limit_flag_i,
  input  wire        ok_flag_i,
  input  wire        lower_limit_flag_i,
  input  wire        sys_fault_i,
  input  wire        cal_fault_i,
  input  wire        range_fault_i,
  // control inputs
  input  wire        term_zero_i,
  input  wire        term_hold_i,
  input  wire        term_clear_i,
  input  wire        rio_zero_i,
  input  wire        rio_hold_i,
  input  wire        rio_clear_i,
  input  wire        store_cmd_i,
  input  wire        rio_store_i,
  output reg         ctrl_zero_o,
  output reg         ctrl_hold_o,
  output reg         ctrl_clear_o,
  output reg         store_trig_o,
  // setpoints
  output reg  [31:0] upper_limit_setpoint_o,
  output reg  [31:0] lower_limit_setpoint_o,
  output reg  [31:0] near_zero_setpoint_o,
  output reg  [31:0] hysteresis_setting_o,
  // actions
  output reg         zero_apply_o,
  output reg         zero_clear_o,
  output reg         hold_start_o,
  output reg         hold_end_o,
  output reg         hold_lock_o,
  output reg         hold_clear_o,
  output reg         home_screen_o,
  output reg         strain_disp_o,
  output reg  [1:0]  command_state_byte_o,
  // lamps
  output reg         run_lamp_o,
  output reg         err_lamp_o,
  output reg         transmit_lamp_o,
  output reg         receive_lamp_o
);
  // --------------------
  // reset release and input synchronisers
  // --------------------
  localparam ST_IDLE = 2'h0;
  localparam ST_EXEC = 2'h1;

  reg  [1:0]  rst_pipe;
  wire        rst_n = rst_pipe[1];
  wire [4:0]  pin_sync;
  wire        carrier_s = pin_sync[0];
  wire        tx_s      = pin_sync[1];
  wire        tzero_s   = pin_sync[2];
  wire        thold_s   = pin_sync[3];
  wire        tclear_s  = pin_sync[4];

  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end

  fbsl_sync #(.WIDTH(5)) u_sync (
    .clk_i   (clk_i),
    .rst_n_i (rst_n),
    .async_i ({term_clear_i, term_hold_i, term_zero_i, transmitting_i, carrier_i}),
    .sync_o  (pin_sync)
  );

  // --------------------
  // settings
  // --------------------
  reg         ctrl_src;
  reg         mem_src;
  reg         loaded;
  reg  [1:0]  state;
  reg  [15:0] cmd_code;
  reg  [31:0] cmd_arg;
  reg  [31:0] cmd_result;
  reg  [15:0] cmd_echo;
  reg         cmd_fault;
  reg         net_set_we;
  reg         net_set_ok;
  reg  [6:0]  next_stn_max;
  reg  [6:0]  act_stn_max;
  reg  [15:0] sel_num;
  reg  [15:0] sel_val;
  reg         sel_we;
  reg         sel_ok;

  // station upper bound shrinks with stations occupied
  always @* begin
    case (pend_stations_o)
      2'h0:    next_stn_max = `FBSL_STN_MAX_4;
      2'h1:    next_stn_max = `FBSL_STN_MAX_2;
      default: next_stn_max = `FBSL_STN_MAX_1;
    endcase
    case (act_stations_o)
      2'h0:    act_stn_max = `FBSL_STN_MAX_4;
      2'h1:    act_stn_max = `FBSL_STN_MAX_2;
      default: act_stn_max = `FBSL_STN_MAX_1;
    endcase
  end

  wire        is_set  = (cmd_code == `FBSL_SET_CTRL_SRC) || (cmd_code == `FBSL_SET_MEM_SRC) ||
                        (cmd_code == `FBSL_SET_STATIONS) || (cmd_code == `FBSL_SET_STN_NO) ||
                        (cmd_code == `FBSL_SET_SPEED);
  // exec checks a network setting here too; a local write meanwhile is lost
  wire        use_net = net_set_we | ((state == ST_EXEC) & is_set);

  // network setting commands take the port over local writes
  always @* begin
    sel_we  = net_set_we | (set_we_i & ~use_net);
    sel_num = use_net ? cmd_code : set_num_i;
    sel_val = use_net ? cmd_arg[15:0] : set_val_i;
    if (sel_num == `FBSL_SET_CTRL_SRC || sel_num == `FBSL_SET_MEM_SRC) begin
      sel_ok = (sel_val <= 16'h0001);
    end else if (sel_num == `FBSL_SET_STATIONS) begin
      sel_ok = (sel_val <= {14'h0000, `FBSL_STATIONS_MAX});
    end else if (sel_num == `FBSL_SET_STN_NO) begin
      sel_ok = (sel_val >= {9'h000, `FBSL_STN_MIN}) && (sel_val <= {9'h000, next_stn_max});
    end else if (sel_num == `FBSL_SET_SPEED) begin
      sel_ok = (sel_val <= {13'h0000, `FBSL_SPEED_MAX});
    end else begin
      sel_ok = 1'b0;
    end
  end

  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      loaded            <= 1'b0;
      ctrl_src          <= 1'b0;
      mem_src           <= 1'b0;
      pend_stations_o   <= 2'h0;
      pend_station_no_o <= `FBSL_STN_MIN;
      pend_speed_o      <= 3'h0;
      act_stations_o    <= 2'h0;
      act_station_no_o  <= `FBSL_STN_MIN;
      act_speed_o       <= 3'h0;
      set_err_o         <= 1'b0;
    end else if (!loaded) begin
      loaded            <= 1'b1;
      ctrl_src          <= nv_ctrl_src_i;
      mem_src           <= nv_mem_src_i;
      pend_stations_o   <= nv_stations_i;
      pend_station_no_o <= nv_station_no_i;
      pend_speed_o      <= nv_speed_i;
      act_stations_o    <= nv_stations_i;
      act_station_no_o  <= nv_station_no_i;
      act_speed_o       <= nv_speed_i;
      set_err_o         <= 1'b0;
    end else begin
      set_err_o <= sel_we & ~sel_ok & ~net_set_we;
      if (sel_we && sel_ok) begin
        if (sel_num == `FBSL_SET_CTRL_SRC) begin
          ctrl_src <= sel_val[0];
        end else if (sel_num == `FBSL_SET_MEM_SRC) begin
          mem_src <= sel_val[0];
        end else if (sel_num == `FBSL_SET_STATIONS) begin
          pend_stations_o <= sel_val[1:0];
        end else if (sel_num == `FBSL_SET_STN_NO) begin
          pend_station_no_o <= sel_val[6:0];
        end else begin
          pend_speed_o <= sel_val[2:0];
        end
      end
    end
  end

  // --------------------
  // control source and store trigger
  // --------------------
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_zero_o  <= 1'b0;
      ctrl_hold_o  <= 1'b0;
      ctrl_clear_o <= 1'b0;
      store_trig_o <= 1'b0;
    end else begin
      ctrl_zero_o  <= ctrl_src ? rio_zero_i  : tzero_s;
      ctrl_hold_o  <= ctrl_src ? rio_hold_i  : thold_s;
      ctrl_clear_o <= ctrl_src ? rio_clear_i : tclear_s;
      store_trig_o <= mem_src ? rio_store_i : store_cmd_i;
    end
  end

  // --------------------
  // output words and command sequencer
  // --------------------
  wire wr_code = link_we_i && (link_addr_i == `FBSL_ADR_CODE);

  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      upper_limit_setpoint_o <= 32'h00000000;
      lower_limit_setpoint_o <= 32'h00000000;
      near_zero_setpoint_o   <= 32'h00000000;
      hysteresis_setting_o   <= 32'h00000000;
      cmd_arg                <= 32'h00000000;
    end else if (link_we_i) begin
      if (link_addr_i == `FBSL_ADR_UPPER_LO) begin
        upper_limit_setpoint_o[15:0] <= link_wdata_i;
      end else if (link_addr_i == `FBSL_ADR_UPPER_HI) begin
        upper_limit_setpoint_o[31:16] <= link_wdata_i;
      end else if (link_addr_i == `FBSL_ADR_LOWER_LO) begin
        lower_limit_setpoint_o[15:0] <= link_wdata_i;
      end else if (link_addr_i == `FBSL_ADR_LOWER_HI) begin
        lower_limit_setpoint_o[31:16] <= link_wdata_i;
      end else if (link_addr_i == `FBSL_ADR_NEAR_LO) begin
        near_zero_setpoint_o[15:0] <= link_wdata_i;
      end else if (link_addr_i == `FBSL_ADR_NEAR_HI) begin
        near_zero_setpoint_o[31:16] <= link_wdata_i;
      end else if (link_addr_i == `FBSL_ADR_HYST_LO) begin
        hysteresis_setting_o[15:0] <= link_wdata_i;
      end else if (link_addr_i == `FBSL_ADR_HYST_HI) begin
        hysteresis_setting_o[31:16] <= link_wdata_i;
      end else if (link_addr_i == `FBSL_ADR_ARG_LO) begin
        cmd_arg[15:0] <= link_wdata_i;
      end else if (link_addr_i == `FBSL_ADR_ARG_HI) begin
        cmd_arg[31:16] <= link_wdata_i;
      end
    end
  end

  // a code written while executing is dropped; the master must wait for standby
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state                <= ST_IDLE;
      cmd_code             <= 16'h0000;
      cmd_echo             <= 16'h0000;
      cmd_result           <= 32'h00000000;
      cmd_fault            <= 1'b0;
      net_set_we           <= 1'b0;
      command_state_byte_o <= `FBSL_CST_STANDBY;
      {zero_apply_o, zero_clear_o, hold_start_o, hold_end_o} <= 4'h0;
      {hold_lock_o, hold_clear_o, home_screen_o, strain_disp_o} <= 4'h0;
    end else begin
      {zero_apply_o, zero_clear_o, hold_start_o, hold_end_o} <= 4'h0;
      {hold_lock_o, hold_clear_o, home_screen_o, strain_disp_o} <= 4'h0;
      net_set_we <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (wr_code) begin
            cmd_code             <= link_wdata_i;
            state                <= ST_EXEC;
            command_state_byte_o <= `FBSL_CST_EXEC;
          end
        end
        ST_EXEC: begin
          state     <= ST_IDLE;
          cmd_fault <= 1'b0;
          cmd_echo   <= cmd_code;
          cmd_result <= cmd_arg;
          command_state_byte_o <= `FBSL_CST_STANDBY;
          if (cmd_code == `FBSL_CMD_EXEC) begin
            if (cmd_arg == `FBSL_EX_ZERO) begin
              zero_apply_o <= 1'b1;
            end else if (cmd_arg == `FBSL_EX_ZERO_CLR) begin
              zero_clear_o <= 1'b1;
            end else if (cmd_arg == `FBSL_EX_HOLD_ON) begin
              hold_start_o <= 1'b1;
            end else if (cmd_arg == `FBSL_EX_HOLD_OFF) begin
              hold_end_o <= 1'b1;
            end else if (cmd_arg == `FBSL_EX_HOLD_LOCK) begin
              hold_lock_o <= 1'b1;
            end else if (cmd_arg == `FBSL_EX_HOLD_CLR) begin
              hold_clear_o <= 1'b1;
            end else if (cmd_arg == `FBSL_EX_HOME) begin
              home_screen_o <= 1'b1;
            end else if (cmd_arg == `FBSL_EX_STRAIN) begin
              strain_disp_o <= 1'b1;
            end else begin
              cmd_fault            <= 1'b1;
              command_state_byte_o <= `FBSL_CST_ERROR;
            end
          end else if (cmd_code == `FBSL_CMD_POLL || cmd_code == `FBSL_CMD_POLL_ST ||
                       cmd_code == `FBSL_CMD_POLL_VAL) begin
            cmd_result <= display_value_i;
          end else if (is_set && sel_ok) begin
            net_set_we <= 1'b1;
          end else begin
            cmd_fault            <= 1'b1;
            command_state_byte_o <= `FBSL_CST_ERROR;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // --------------------
  // input words
  // --------------------
  reg [15:0] status_word;
  reg [15:0] fault_word;

  always @* begin
    status_word = {over_i, full_i, stable_i, strain_i, 1'b0, point_pos_i,
                   hold_active_i, zone_hold_i, near_zero_i, 1'b0,
                   upper_limit_flag_i, ok_flag_i, lower_limit_flag_i, 1'b0};
    if (sys_fault_i) begin
      fault_word = `FBSL_FLT_SYSTEM;
    end else if (cal_fault_i) begin
      fault_word = `FBSL_FLT_CAL;
    end else if (range_fault_i) begin
      fault_word = `FBSL_FLT_RANGE;
    end else if (cmd_fault) begin
      fault_word = `FBSL_FLT_CMD;
    end else begin
      fault_word = `FBSL_FLT_NONE;
    end
  end

  // output words are write-only and read back as zero
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      link_rdata_o <= 16'h0000;
    end else if (link_re_i) begin
      if (link_addr_i == `FBSL_ADR_DISP_LO) begin
        link_rdata_o <= display_value_i[15:0];
      end else if (link_addr_i == `FBSL_ADR_DISP_HI) begin
        link_rdata_o <= display_value_i[31:16];
      end else if (link_addr_i == `FBSL_ADR_LIVE_LO) begin
        link_rdata_o <= live_input_value_i[15:0];
      end else if (link_addr_i == `FBSL_ADR_LIVE_HI) begin
        link_rdata_o <= live_input_value_i[31:16];
      end else if (link_addr_i == `FBSL_ADR_STATUS) begin
        link_rdata_o <= status_word;
      end else if (link_addr_i == `FBSL_ADR_RES_LO) begin
        link_rdata_o <= cmd_result[15:0];
      end else if (link_addr_i == `FBSL_ADR_RES_HI) begin
        link_rdata_o <= cmd_result[31:16];
      end else if (link_addr_i == `FBSL_ADR_ECHO) begin
        link_rdata_o <= cmd_echo;
      end else if (link_addr_i == `FBSL_ADR_FAULT) begin
        link_rdata_o <= fault_word;
      end else begin
        link_rdata_o <= 16'h0000;
      end
    end
  end

  // --------------------
  // lamps
  // --------------------
  reg  [23:0] blink_cnt;
  reg         blink_phase;
  wire        act_bad  = (act_stations_o > `FBSL_STATIONS_MAX) ||
                         (act_station_no_o < `FBSL_STN_MIN) ||
                         (act_station_no_o > act_stn_max) ||
                         (act_speed_o > `FBSL_SPEED_MAX);
  wire        changed  = (pend_stations_o != act_stations_o) ||
                         (pend_station_no_o != act_station_no_o) ||
                         (pend_speed_o != act_speed_o);

  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      blink_cnt       <= 24'h000000;
      blink_phase     <= 1'b0;
      run_lamp_o      <= 1'b0;
      err_lamp_o      <= 1'b0;
      transmit_lamp_o <= 1'b0;
      receive_lamp_o  <= 1'b0;
    end else begin
      if (blink_cnt == BLINK_CYC[23:0] - 24'h000001) begin
        blink_cnt   <= 24'h000000;
        blink_phase <= ~blink_phase;
      end else begin
        blink_cnt <= blink_cnt + 24'h000001;
      end
      run_lamp_o <= joined_i & refresh_ok_i & carrier_s & ~timeout_i;
      if (crc_err_i || act_bad) begin
        err_lamp_o <= 1'b1;
      end else if (changed && joined_i) begin
        err_lamp_o <= blink_phase;
      end else begin
        err_lamp_o <= 1'b0;
      end
      transmit_lamp_o <= tx_s;
      receive_lamp_o  <= carrier_s;
    end
  end
endmodule

// [test/fbsl_props.sv]
// concurrent checks on the fieldbus slave command map ports
`timescale 1ns/100ps
module fbsl_props #(
  parameter BLINK_CYC = 4
) (
  input wire        clk_i,
  input wire        nrst_i,
  input wire [9:0]  link_addr_i,
  input wire        link_we_i,
  input wire [1:0]  command_state_byte_o,
  input wire        zero_apply_o,
  input wire        joined_i,
  input wire        timeout_i,
  input wire        carrier_i,
  input wire        run_lamp_o,
  input wire        crc_err_i,
  input wire        err_lamp_o,
  input wire        receive_lamp_o,
  input wire        transmitting_i,
  input wire        transmit_lamp_o,
  input wire        set_we_i,
  input wire [15:0] set_num_i,
  input wire [15:0] set_val_i,
  input wire        set_err_o,
  input wire [2:0]  act_speed_o
);
  // internal reset and pin syncs lag the pin, so wait before judging
  reg  [3:0] up_cnt;
  wire       up = up_cnt == 4'hF;
  wire       cw = up && link_we_i && link_addr_i == 10'h1EE && command_state_byte_o != 2'h1;
  wire       sw = up && set_we_i && set_num_i == 16'h5103;
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) up_cnt <= 4'h0;
    else if (!up) up_cnt <= up_cnt + 4'h1;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  a_exec_enter: assert property (cw |=> command_state_byte_o == 2'h1)
    else $error("command not taken");
  a_zero_pulse: assert property (zero_apply_o |-> $past(command_state_byte_o) == 2'h1 ##1 !zero_apply_o)
    else $error("zero pulse wrong");
  a_run_off: assert property (up && (!joined_i || timeout_i) |=> !run_lamp_o)
    else $error("run lamp lit");
  a_err_crc: assert property (up && crc_err_i |=> err_lamp_o)
    else $error("error lamp dark");
  a_rx_lamp: assert property (up && carrier_i [*4] |-> receive_lamp_o)
    else $error("receive lamp dark");
  a_tx_lamp: assert property (up && transmitting_i [*4] |-> transmit_lamp_o)
    else $error("transmit lamp dark");
  a_speed_bad: assert property (sw && set_val_i > 16'h4 |=> set_err_o)
    else $error("bad speed kept");
  a_act_frozen: assert property (up && $past(up) |-> $stable(act_speed_o))
    else $error("active speed moved");
endmodule
bind fbsl_top fbsl_props #(.BLINK_CYC(BLINK_CYC)) u_props (.*);

// [test/fbsl_master.sv]
// master station model driving the link state levels
`timescale 1ns/100ps
module fbsl_master (
  input  wire       clk_i,
  input  wire [2:0] mode_i,
  output reg        carrier_o = 1'b0,
  output reg        transmitting_o = 1'b0,
  output reg        joined_o = 1'b0,
  output reg        refresh_ok_o = 1'b0,
  output reg        timeout_o = 1'b0,
  output reg        crc_err_o = 1'b0
);
  // modes: 0 off line, 1 polling, 2 timed out, 3 corrupt frames
  always @(posedge clk_i) begin
    carrier_o <= mode_i != 3'h0;
    transmitting_o <= mode_i == 3'h1;
    joined_o <= mode_i != 3'h0;
    refresh_ok_o <= mode_i == 3'h1 || mode_i == 3'h3;
    timeout_o <= mode_i == 3'h2;
    crc_err_o <= mode_i == 3'h3;
  end
endmodule

// [test/fbsl_top_tb_top.sv]
// self-checking bench for the fieldbus slave command map
`timescale 1ns/100ps
module fbsl_top_tb_top;
  logic clk_i = 0, nrst_i = 0, link_we_i = 0, link_re_i = 0, set_we_i = 0;
  logic nv_ctrl_src_i = 0, nv_mem_src_i = 0;
  logic [9:0] link_addr_i = 0;
  logic [15:0] link_wdata_i = 0, set_num_i = 0, set_val_i = 0, r;
  logic [1:0] nv_stations_i = 1;
  logic [6:0] nv_station_no_i = 5;
  logic [2:0] nv_speed_i = 2, mode = 0;
  logic [31:0] display_value_i = 0, live_input_value_i = 0, x;
  logic [23:0] iv = 0;
  logic [7:0] seen = 0;
  wire [15:0] link_rdata_o;
  wire carrier_i, transmitting_i, joined_i, refresh_ok_i, timeout_i, crc_err_i;
  wire over_i, full_i, stable_i, strain_i, hold_active_i, zone_hold_i, near_zero_i;
  wire upper_limit_flag_i, ok_flag_i, lower_limit_flag_i, sys_fault_i, cal_fault_i;
  wire range_fault_i, term_zero_i, term_hold_i, term_clear_i, rio_zero_i, rio_hold_i;
  wire rio_clear_i, store_cmd_i, rio_store_i, set_err_o, ctrl_zero_o, ctrl_hold_o;
  wire ctrl_clear_o, store_trig_o, zero_apply_o, zero_clear_o, hold_start_o, hold_end_o;
  wire hold_lock_o, hold_clear_o, home_screen_o, strain_disp_o, run_lamp_o, err_lamp_o;
  wire transmit_lamp_o, receive_lamp_o;
  wire [2:0] point_pos_i, pend_speed_o, act_speed_o;
  wire [1:0] pend_stations_o, act_stations_o, command_state_byte_o;
  wire [6:0] pend_station_no_o, act_station_no_o;
  wire [31:0] upper_limit_setpoint_o, lower_limit_setpoint_o, near_zero_setpoint_o;
  wire [31:0] hysteresis_setting_o;
  int bad_count = 0, samples_checked = 0;
  int codes[8] = '{'h10, 'h11, 'h12, 'h13, 'h14, 'h15, 'h17, 'h20};
  assign {sys_fault_i, cal_fault_i, range_fault_i, term_zero_i, term_hold_i, term_clear_i,
          rio_zero_i, rio_hold_i, rio_clear_i, store_cmd_i, rio_store_i, over_i, full_i,
          stable_i, strain_i, point_pos_i, hold_active_i, zone_hold_i, near_zero_i,
          upper_limit_flag_i, ok_flag_i, lower_limit_flag_i} = iv;
  fbsl_top #(.BLINK_CYC(4)) uut (.*);
  fbsl_master u_master (.clk_i(clk_i), .mode_i(mode), .carrier_o(carrier_i),
    .transmitting_o(transmitting_i), .joined_o(joined_i), .refresh_ok_o(refresh_ok_i),
    .timeout_o(timeout_i), .crc_err_o(crc_err_i));
  always #25 clk_i = ~clk_i;
  always @(posedge clk_i) seen <= seen | {strain_disp_o, home_screen_o, hold_clear_o,
    hold_lock_o, hold_end_o, hold_start_o, zero_clear_o, zero_apply_o};
  task chk(input string n, input logic [31:0] e, input logic [31:0] s);
    samples_checked++;
    if (s !== e) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task wr(input [9:0] a, input [15:0] d);
    @(posedge clk_i);
    link_addr_i <= a;
    link_wdata_i <= d;
    link_we_i <= 1;
    @(posedge clk_i);
    link_we_i <= 0;
  endtask
  task rd(input [9:0] a, input [15:0] e, input string n);
    @(posedge clk_i);
    link_addr_i <= a;
    link_re_i <= 1;
    @(posedge clk_i);
    link_re_i <= 0;
    @(negedge clk_i);
    chk(n, e, link_rdata_o);
  endtask
  // argument first, then code; the fixed wait reaches standby again
  task cmd(input [15:0] c, input [31:0] a);
    wr(10'h1EC, a[15:0]);
    wr(10'h1ED, a[31:16]);
    // one command at a time, next only after standby
    wr(10'h1EE, c);
    repeat (4) @(negedge clk_i);
  endtask
  task lset(input [15:0] n, input [15:0] v, input e);
    @(posedge clk_i);
    set_num_i <= n;
    set_val_i <= v;
    set_we_i <= 1;
    @(posedge clk_i);
    set_we_i <= 0;
    @(negedge clk_i);
    chk("set_err", e, set_err_o);
  endtask
  task close_out;
    $display("checked %0d bad %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    #1000000;
    bad_count++;
    close_out;
  end
  initial begin
    x = $urandom(21);
    repeat (16) @(posedge clk_i);
    nrst_i <= 1;
    repeat (6) @(posedge clk_i);
    iv <= $urandom & 24'h1FFEFF;
    display_value_i <= $urandom;
    x = $urandom;
    chk("act_speed", 2, act_speed_o);
    wr(10'h1E2, x[15:0]);
    wr(10'h1E3, x[31:16]);
    @(negedge clk_i);
    chk("upper", x, upper_limit_setpoint_o);
    rd(10'h1E2, 0, "wo_read");
    rd(10'h2E0, display_value_i[15:0], "disp");
    rd(10'h2E4, {iv[12:9], 1'b0, iv[8:6], iv[5:3], 1'b0, iv[2:0], 1'b0}, "status");
    for (int i = 0; i < 8; i++) begin
      cmd(16'h0000, codes[i]);
      chk("pulses", (2 << i) - 1, seen);
      chk("state", 0, command_state_byte_o);
      rd(10'h2EE, 0, "echo");
      rd(10'h2EC, codes[i], "result");
    end
    cmd(16'h0000, 'h99);
    chk("state", 2, command_state_byte_o);
    rd(10'h2EF, 4, "fault");
    cmd(16'h0000, 'h17);
    rd(10'h2EF, 0, "fault");
    chk("ctrl_term", iv[20], ctrl_zero_o);
    chk("store_man", iv[14], store_trig_o);
    lset(16'h5710, 1, 0);
    lset(16'h5711, 1, 0);
    repeat (2) @(negedge clk_i);
    chk("ctrl_net", iv[17], ctrl_zero_o);
    chk("store_net", iv[13], store_trig_o);
    lset(16'h5103, 3, 0);
    lset(16'h5103, 5, 1);
    chk("pend_speed", 3, pend_speed_o);
    chk("act_speed", 2, act_speed_o);
    lset(16'h5101, 2, 0);
    lset(16'h5102, 64, 0);
    lset(16'h5101, 0, 0);
    lset(16'h5102, 64, 1);
    chk("pend_stn", 64, pend_station_no_o);
    cmd(16'h5103, 1);
    chk("net_speed", 1, pend_speed_o);
    mode <= 1;
    repeat (8) @(negedge clk_i);
    chk("run", 1, run_lamp_o);
    chk("tx", 1, transmit_lamp_o);
    chk("rx", 1, receive_lamp_o);
    r = err_lamp_o;
    repeat (4) @(negedge clk_i);
    chk("blink", !r[0], err_lamp_o);
    mode <= 2;
    repeat (4) @(negedge clk_i);
    chk("run", 0, run_lamp_o);
    mode <= 3;
    repeat (4) @(negedge clk_i);
    chk("err", 1, err_lamp_o);
    mode <= 0;
    iv[23] <= 1;
    repeat (6) @(negedge clk_i);
    chk("rx", 0, receive_lamp_o);
    rd(10'h2EF, 1, "fault");
    close_out;
  end
endmodule
